// [core/reload_timer_consts.vh]
// Constants for the reload timer with square wave output.
// Assumes inclusion by bare name from core/.
`ifndef RELOAD_TIMER_CONSTS_VH
`define RELOAD_TIMER_CONSTS_VH
`define ADDR_TIMER_MODE       4'h0
`define ADDR_RELOAD_COUNT     4'h1
`define ADDR_PIN_WAVEFORM     4'h2
`define ADDR_IRQ_STATUS       4'h3
`define ADDR_IRQ_MASK         4'h4
`define ADDR_PORT_MODE_ONE    4'h5
`define TIMER_MODE_RESET      8'h78
`define TIMER_MODE_RSVD       8'h78
`define RELOAD_RESET          8'h00
`define COUNT_RESET           8'h00
`define PIN_WAVEFORM_RESET    8'h0f
`define PIN_WAVEFORM_RSVD     8'h0f
`define BIT_RELOAD_MODE       7
`define BIT_WAVE_PIN_SEL      7
`define BIT_WAVE_OUT_ON       6
`define BIT_FIXED_RATE        5
`define BIT_VARIABLE_RATE     4
`define BIT_EXT_IRQ_PIN_SEL   5
`define PRESCALE_WIDTH        13
`define FIXED_SLOW_BIT        10
`define FIXED_FAST_BIT        9
`endif

// [core/tap_pulse_gen.v]
// Free-running prescaler giving a one-cycle pulse from one of eight taps.
// Assumes one system clock; pulse k fires once per divide period.
`timescale 1ns/100ps
`include "reload_timer_consts.vh"
module tap_pulse_gen (
   input  wire        mclk,
   input  wire        rst_b,
   input  wire [2:0]  tapSel,
   output reg         tapPulse,
   output wire [`PRESCALE_WIDTH-1:0] prescale
);
   reg  [`PRESCALE_WIDTH-1:0] prescale_q;
   wire [`PRESCALE_WIDTH-1:0] prescale_d;
   reg  [`PRESCALE_WIDTH-1:0] prev_q;
   assign prescale_d = prescale_q + 13'h0001;
   assign prescale   = prescale_q;

   function [3:0] tapBit;
      input [2:0] sel;
      begin
         case (sel)
            3'h0:    tapBit = 4'hc;  // divide by 8192
            3'h1:    tapBit = 4'hb;  // divide by 4096
            3'h2:    tapBit = 4'ha;  // divide by 2048
            3'h3:    tapBit = 4'h8;  // divide by 512
            3'h4:    tapBit = 4'h7;  // divide by 256
            3'h5:    tapBit = 4'h6;  // divide by 128
            3'h6:    tapBit = 4'h4;  // divide by 32
            default: tapBit = 4'h2;  // divide by 8
         endcase
      end
   endfunction

   always @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         prescale_q <= 13'h0000;
         prev_q     <= 13'h0000;
      end else begin
         prescale_q <= prescale_d;
         prev_q     <= prescale_q;
      end
   end

   // Falling edge of the chosen prescaler bit marks one tap period
   always @* begin
      tapPulse = prev_q[tapBit(tapSel)] & ~prescale_q[tapBit(tapSel)];
   end
endmodule

// [core/reload_timer_square_wave.v]
// Eight-bit reload timer with interrupt and shared-pin waveform output.
// Assumes a single-cycle register port and a two-way shared pin resolved outside.
`timescale 1ns/100ps
`include "reload_timer_consts.vh"
// Operation
// - Eight-bit write-only reload register, zero after reset.
// - Writing reload also loads the counter at once, either mode.
// - Reload and counter share one address: write reload, read count.
// - Auto-reload mode: overflow from all ones loads the reload value.
// - Interval mode: overflow from all ones wraps the counter to zero.
// - Every overflow sets the flag; interrupt only while enabled.
// - Reset clears counter, selects interval mode, counting starts at once.
// - Counter steps on pulses from one of eight prescaler taps.
// - Tap codes map from divide-by-8192 down to divide-by-8.
// - External interrupt pin select makes the pin an interrupt input.
// - Both selects zero leave the pin an ordinary port pin.
// - Waveform selected but output off drives the pin low.
// - Fixed rate output: clock over 2048 or 1024, half duty.
// - Variable rate output toggles on every counter overflow.
// - Pin waveform register resets to 0f; low four bits read one.
module reload_timer_square_wave (
   input  wire       mclk,
   input  wire       rst_b,
   input  wire [3:0] regAddr,
   input  wire [7:0] regWrData,
   input  wire       regWr,
   input  wire       regRd,
   output reg  [7:0] regRdData,
   output wire       irq,
   input  wire       pinIn,
   output wire       pinOut,
   output wire       pinOe,
   input  wire       portOut,
   input  wire       portOe,
   output wire       portIn,
   output wire       extIrqIn
);
   reg  [7:0] timerMode_q;
   reg  [7:0] reloadValue_q;
   reg  [7:0] countValue_q;
   reg  [7:0] countValue_d;
   reg  [3:0] pinWave_q;
   reg        overflowFlag_q;
   reg        overflowIntEn_q;
   reg        extIrqPinSel_q;
   reg        toggleOut_q;
   reg        pinSync1_q;
   reg        pinSync2_q;
   wire       tapPulse;
   wire [`PRESCALE_WIDTH-1:0] prescale;
   wire       overflow;
   wire       reloadMode;
   wire       wavePinSel;
   wire       waveOutOn;
   wire       fixedRate;
   wire       variableRate;
   wire       waveLevel;
   wire       toggleSelected;
   wire       wrReload;

   tap_pulse_gen prescaler (
      .mclk     (mclk),
      .rst_b    (rst_b),
      .tapSel   (timerMode_q[2:0]),
      .tapPulse (tapPulse),
      .prescale (prescale)
   );

   assign reloadMode   = timerMode_q[`BIT_RELOAD_MODE];
   assign wavePinSel   = pinWave_q[`BIT_WAVE_PIN_SEL-4];
   assign waveOutOn    = pinWave_q[`BIT_WAVE_OUT_ON-4];
   assign fixedRate    = pinWave_q[`BIT_FIXED_RATE-4];
   assign variableRate = pinWave_q[`BIT_VARIABLE_RATE-4];
   assign wrReload     = regWr & (regAddr == `ADDR_RELOAD_COUNT);
   assign overflow     = tapPulse & (countValue_q == 8'hff) & ~wrReload;
   assign toggleSelected = wavePinSel & waveOutOn & variableRate;

   // Register writes; the write wins over a same-cycle count step
   always @* begin
      countValue_d = countValue_q;
      if (wrReload) begin
         countValue_d = regWrData;
      end else if (overflow) begin
         countValue_d = reloadMode ? reloadValue_q : 8'h00;
      end else if (tapPulse) begin
         countValue_d = countValue_q + 8'h01;
      end
   end

   always @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         timerMode_q     <= `TIMER_MODE_RESET;
         reloadValue_q   <= `RELOAD_RESET;
         countValue_q    <= `COUNT_RESET;
         pinWave_q       <= 4'h0;
         overflowIntEn_q <= 1'b0;
         extIrqPinSel_q  <= 1'b0;
      end else begin
         countValue_q <= countValue_d;
         if (regWr) begin
            case (regAddr)
               `ADDR_TIMER_MODE:    timerMode_q <= {regWrData[7], 4'hf, regWrData[2:0]};
               `ADDR_RELOAD_COUNT:  reloadValue_q <= regWrData;
               `ADDR_PIN_WAVEFORM:  pinWave_q <= regWrData[7:4];
               `ADDR_IRQ_MASK:      overflowIntEn_q <= regWrData[0];
               `ADDR_PORT_MODE_ONE: extIrqPinSel_q <= regWrData[`BIT_EXT_IRQ_PIN_SEL];
               default:             overflowIntEn_q <= overflowIntEn_q;
            endcase
         end
      end
   end

   // Set wins over a write-one clear in the same cycle
   always @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         overflowFlag_q <= 1'b0;
      end else if (overflow) begin
         overflowFlag_q <= 1'b1;
      end else if (regWr & (regAddr == `ADDR_IRQ_STATUS) & regWrData[0]) begin
         overflowFlag_q <= 1'b0;
      end
   end

   assign irq = overflowFlag_q & overflowIntEn_q;

   // Read data is registered, valid the cycle after the strobe
   always @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         regRdData <= 8'h00;
      end else if (regRd) begin
         case (regAddr)
            `ADDR_TIMER_MODE:    regRdData <= timerMode_q | `TIMER_MODE_RSVD;
            `ADDR_RELOAD_COUNT:  regRdData <= countValue_q;
            `ADDR_PIN_WAVEFORM:  regRdData <= {pinWave_q, 4'hf};
            `ADDR_IRQ_STATUS:    regRdData <= {7'h00, overflowFlag_q};
            `ADDR_IRQ_MASK:      regRdData <= {7'h00, overflowIntEn_q};
            `ADDR_PORT_MODE_ONE: regRdData <= {2'h0, extIrqPinSel_q, 5'h00};
            default:             regRdData <= 8'h00;
         endcase
      end else begin
         regRdData <= 8'h00;
      end
   end

   // Toggle starts low each time it is selected, so the phase is known
   always @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         toggleOut_q <= 1'b0;
      end else if (!toggleSelected) begin
         toggleOut_q <= 1'b0;
      end else if (overflow) begin
         toggleOut_q <= ~toggleOut_q;
      end
   end

   // Pin input is asynchronous to mclk
   always @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         pinSync1_q <= 1'b0;
         pinSync2_q <= 1'b0;
      end else begin
         pinSync1_q <= pinIn;
         pinSync2_q <= pinSync1_q;
      end
   end

   // Prescaler bit 10 has period 2048, bit 9 period 1024, both half duty
   assign waveLevel = !waveOutOn ? 1'b0 :
                      variableRate ? toggleOut_q :
                      (fixedRate ? prescale[`FIXED_FAST_BIT] : prescale[`FIXED_SLOW_BIT]);

   assign pinOe    = extIrqPinSel_q ? 1'b0 : (wavePinSel ? 1'b1 : portOe);
   assign pinOut   = extIrqPinSel_q ? 1'b0 : (wavePinSel ? waveLevel : portOut);
   assign extIrqIn = extIrqPinSel_q ? pinSync2_q : 1'b1;
   assign portIn   = pinSync2_q;
endmodule

// [sim/reload_timer_monitor.sv]
// Port checker for the reload timer.
// Assumes it is bound to every reload_timer_square_wave instance.
`timescale 1ns/100ps
module reload_timer_monitor (
   input wire       mclk,
   input wire       rst_b,
   input wire [3:0] regAddr,
   input wire [7:0] regWrData,
   input wire       regWr,
   input wire       regRd,
   input wire [7:0] regRdData,
   input wire       irq,
   input wire       pinOe,
   input wire       portOe,
   input wire       extIrqIn
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_b);
   a_rd_idle_zero: assert property (!$past(regRd) |-> regRdData == 8'h00)
      else $error("read data outside its slot");
   a_reload_to_count: assert property (regWr && regAddr == 4'h1 ##1 regRd && regAddr == 4'h1
      |=> regRdData == $past(regWrData, 2)) else $error("count not loaded by reload write");
   a_irq_has_flag: assert property (regRd && regAddr == 4'h3 && irq |=> regRdData[0])
      else $error("irq without overflow flag");
   a_irq_masked: assert property (regWr && regAddr == 4'h4 && !regWrData[0] |=> !irq)
      else $error("irq while disabled");
   a_unmapped_zero: assert property (regRd && regAddr > 4'h5 |=> regRdData == 8'h00)
      else $error("unmapped read not zero");
   a_wave_reserved: assert property (regRd && regAddr == 4'h2 |=> regRdData[3:0] == 4'hf)
      else $error("reserved bits not one");
   a_ext_pin_input: assert property (!extIrqIn |-> !pinOe)
      else $error("pin driven in interrupt mode");
   a_port_owns_pin: assert property ($changed(pinOe) && !$past(regWr) |-> pinOe == portOe)
      else $error("pin enable changed without port");
endmodule
bind reload_timer_square_wave reload_timer_monitor mon (.*);

// [sim/tb.sv]
// Self-checking bench for the reload timer.
// Assumes the design and its checker are compiled first.
`timescale 1ns/100ps
module tb;
   reg         mclk = 0, rst_b = 0, regWr = 0, regRd = 0, pinIn = 1, portOut = 0, portOe = 0;
   reg  [3:0]  regAddr = 4'h0;
   reg  [7:0]  regWrData = 8'h00, d;
   reg  [19:0] rows [0:5];
   wire [7:0]  regRdData;
   wire        irq, pinOut, pinOe, portIn, extIrqIn;
   integer     fail_count = 0, cmp_count = 0, i, n;
   always #2 mclk = ~mclk;
   reload_timer_square_wave dut (.mclk(mclk), .rst_b(rst_b), .regAddr(regAddr), .regWrData(regWrData),
      .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .irq(irq), .pinIn(pinIn), .pinOut(pinOut),
      .pinOe(pinOe), .portOut(portOut), .portOe(portOe), .portIn(portIn), .extIrqIn(extIrqIn));
   task summarize; begin
      if (fail_count == 0 && cmp_count > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   end endtask
   task chk(input [7:0] g, input [7:0] e); begin
      cmp_count = cmp_count + 1;
      if (g !== e) begin
         fail_count = fail_count + 1;
         $display("[ERR] %0t got %h exp %h", $time, g, e);
      end
   end endtask
   task wr(input [3:0] a, input [7:0] v); begin
      @(posedge mclk);
      regAddr <= a; regWrData <= v; regWr <= 1'b1;
      @(posedge mclk);
      regWr <= 1'b0;
   end endtask
   // Starts at an edge so a read can follow a write with no gap
   task rd(input [3:0] a); begin
      regAddr <= a; regRd <= 1'b1;
      @(posedge mclk);
      regRd <= 1'b0;
      @(negedge mclk);
      d = regRdData;
      @(posedge mclk);
   end endtask
   task waitIrq; begin
      n = 0;
      while (irq !== 1'b1 && n < 3000) begin @(posedge mclk); n = n + 1; end
      chk({7'h0, irq}, 8'h01);
      if (irq !== 1'b1) summarize;
   end endtask
   task edges(input integer len); begin
      n = 0;
      // Pin sampled away from the launching edge
      @(negedge mclk);
      d[0] = pinOut;
      repeat (len) begin @(negedge mclk); if (pinOut !== d[0]) n = n + 1; d[0] = pinOut; end
   end endtask
   initial begin
      rows[0] = {4'h1, 8'h5a, 8'h5a}; rows[1] = {4'h2, 8'hf0, 8'hff}; rows[2] = {4'h2, 8'h50, 8'h5f};
      rows[3] = {4'h0, 8'h87, 8'hff}; rows[4] = {4'h0, 8'h00, 8'h78}; rows[5] = {4'h9, 8'h5a, 8'h00};
      repeat (8) @(posedge mclk);
      rst_b <= 1'b1;
      rd(4'h2); chk(d, 8'h0f);
      rd(4'h0); chk(d, 8'h78);
      rd(4'h1); chk(d, 8'h00);
      for (i = 0; i < 6; i = i + 1) begin
         wr(rows[i][19:16], rows[i][15:8]);
         rd(rows[i][19:16]); chk(d, rows[i][7:0]);
      end
      portOut <= 1'b1; portOe <= 1'b1;
      @(posedge mclk); @(posedge mclk); chk({pinOe, pinOut}, 8'h03);
      wr(4'h0, 8'h07); wr(4'h3, 8'h01); wr(4'h4, 8'h01); wr(4'h1, 8'hfe);
      waitIrq;
      rd(4'h3); chk({7'h0, d[0]}, 8'h01);
      rd(4'h1); chk({d[7:1], 1'b0}, 8'h00);
      wr(4'h3, 8'h01); @(posedge mclk); chk({7'h0, irq}, 8'h00);
      wr(4'h4, 8'h00); wr(4'h1, 8'hff); repeat (40) @(posedge mclk);
      chk({7'h0, irq}, 8'h00);
      wr(4'h0, 8'h87); wr(4'h3, 8'h01); wr(4'h4, 8'h01); wr(4'h1, 8'hf0);
      waitIrq;
      rd(4'h1); chk({d[7:1], 1'b0}, 8'hf0);
      wr(4'h1, 8'hff); wr(4'h2, 8'hd0); edges(64); chk(n[7:0], 8'h08);
      wr(4'h2, 8'hf0); edges(64); chk(n[7:0], 8'h08);
      wr(4'h2, 8'hc0); edges(4096); chk(n[7:0], 8'h04);
      wr(4'h2, 8'he0); edges(4096); chk(n[7:0], 8'h08);
      wr(4'h2, 8'h80); @(posedge mclk); chk({pinOe, pinOut}, 8'h02);
      wr(4'h5, 8'h20); pinIn <= 1'b0; repeat (4) @(posedge mclk);
      chk({pinOe, extIrqIn}, 8'h00);
      summarize;
   end
endmodule
